// *** verilog/clpd_pkg.sv ***
// shared constants and types of the cold load pick-up detector
package clpd_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CUR_W = 16;                 // magnitude in 0.01 x nominal
    localparam int TMR_W = 19;                 // timer in 5 ms ticks, up to 1800 s
    localparam int CNT_W = 32;

    // ------------------------------------------------------------
    // timing: timers count measurement ticks
    // ------------------------------------------------------------
    localparam int TICK_US      = 5000;        // measurement cadence, 5 ms
    localparam int T_SET_DEF_MS = 10000;       // arming time 10.000 s
    localparam int T_MAX_DEF_MS = 30000;       // inrush maximum 30.000 s
    localparam int T_MIN_DEF_MS = 40;          // minimum hold 0.040 s
    localparam logic [TMR_W-1:0] T_SET_DEF = TMR_W'(T_SET_DEF_MS * 1000 / TICK_US);
    localparam logic [TMR_W-1:0] T_MAX_DEF = TMR_W'(T_MAX_DEF_MS * 1000 / TICK_US);
    localparam logic [TMR_W-1:0] T_MIN_DEF = TMR_W'(T_MIN_DEF_MS * 1000 / TICK_US);
    localparam int HIST_N       = 4;           // 20 ms history = four ticks

    // ------------------------------------------------------------
    // thresholds, in 0.01 x nominal steps, and reset ratio
    // ------------------------------------------------------------
    localparam logic [CUR_W-1:0] I_LOW_DEF  = 16'h0014;   // 0.20
    localparam logic [CUR_W-1:0] I_HIGH_DEF = 16'h0078;   // 1.20
    localparam logic [CUR_W-1:0] I_OVER_DEF = 16'h00c8;   // 2.00
    localparam logic [7:0]       RR_NUM     = 8'h61;      // 97
    localparam logic [7:0]       RR_DEN     = 8'h64;      // 100

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_I_LOW   = 8'h04;
    localparam logic [7:0] OFS_I_HIGH  = 8'h08;
    localparam logic [7:0] OFS_I_OVER  = 8'h0c;
    localparam logic [7:0] OFS_T_SET   = 8'h10;
    localparam logic [7:0] OFS_T_MAX   = 8'h14;
    localparam logic [7:0] OFS_T_MIN   = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_ACT_CNT = 8'h20;
    localparam logic [7:0] OFS_BLK_CNT = 8'h24;
    localparam logic [7:0] OFS_PRE_AB  = 8'h28;
    localparam logic [7:0] OFS_PRE_C   = 8'h2c;
    localparam logic [7:0] OFS_EVT_AB  = 8'h30;
    localparam logic [7:0] OFS_EVT_C   = 8'h34;
    localparam logic [7:0] OFS_EVT_TS  = 8'h38;

    // ctrl bit positions
    localparam int CTRL_FORCE_EN  = 0;
    localparam int CTRL_FORCE_BLK = 1;
    localparam int CTRL_CNT_CLR   = 2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CUR_W-1:0] phase_a_rms;
        logic [CUR_W-1:0] phase_b_rms;
        logic [CUR_W-1:0] phase_c_rms;
    } clpd_phase_t;

    typedef enum logic [2:0] {
        COND_NORMAL  = 3'h0,
        COND_LOW     = 3'h1,
        COND_OVER    = 3'h2,
        COND_ACTIVE  = 3'h3,
        COND_BLOCKED = 3'h4
    } clpd_cond_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_ARMING  = 2'h1,
        ST_ACTIVE  = 2'h2,
        ST_BLOCKED = 2'h3
    } clpd_state_t;
endpackage

// *** verilog/clpd_detector.sv ***
// cold load pick-up detector with apb register access
//
// Function
// - pickup comparators drop out at 97 percent
// - one threshold setting shared by three phases
// - low condition needs all phases below low
// - inrush condition needs all phases above high
// - any phase overcurrent drops active at once
// - block input sampled first in each tick
// - pickup without block asserts active output
// - pickup with block asserts blocked, stops
// - block while active releases active output
// - blocked entry issues stamped event with currents
// - active only after low lasts arming time
// - inrush time limited by maximum timer
// - active held at least minimum hold time
// - maximum timer starts when current exceeds high
// - return below high ends start-up inrush
// - maximum timer expiry drops active output
// - no inrush: release after minimum hold
// - inrush during hold: max or startup end
// - zero arming time activates immediately
// - condition code normal low over active blocked
// - test forcing lets software drive block
// - resettable counts of active and blocked
// - 20 ms averaged history kept for pre-fault
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module clpd_detector (
    // clock, reset, enable
    input  wire  logic                     core_clk,
    input  wire  logic                     arst_n,
    input  wire  logic                     clk_en,
    // apb slave
    input  wire  logic                     psel,
    input  wire  logic                     penable,
    input  wire  logic                     pwrite,
    input  wire  logic [7:0]               paddr,
    input  wire  logic [31:0]              pwdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic [31:0]                    prdata,
    // measurement front end, same clock domain
    input  wire  clpd_pkg::clpd_phase_t    meas,
    input  wire  logic                     meas_valid,
    // blocking matrix pin
    input  wire  logic                     block_in,
    // outputs
    output logic                           cold_load_active,
    output logic                           blocked,
    output logic [2:0]                     condition_code,
    output logic                           block_event
);
    import clpd_pkg::*;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // over-type comparator: picks above setting, drops below 97 %
    function automatic logic cmp_over(logic pu, logic [CUR_W-1:0] m,
                                      logic [CUR_W-1:0] s);
        logic [23:0] mm;
        logic [23:0] ss;
        mm = 24'(m) * 24'(RR_DEN);
        ss = 24'(s) * 24'(RR_NUM);
        cmp_over = pu ? (mm >= ss) : (m > s);
    endfunction

    // under-type comparator: picks below setting, drops above setting/0.97
    function automatic logic cmp_under(logic pu, logic [CUR_W-1:0] m,
                                       logic [CUR_W-1:0] s);
        logic [23:0] mm;
        logic [23:0] ss;
        mm = 24'(m) * 24'(RR_NUM);
        ss = 24'(s) * 24'(RR_DEN);
        cmp_under = pu ? (mm <= ss) : (m < s);
    endfunction

    // a timer expires on the tick its elapsed count reaches the setting
    function automatic logic reached(logic [TMR_W-1:0] cnt, logic [TMR_W-1:0] set);
        reached = (cnt >= set);
    endfunction

    // 20 ms average of four stored samples
    function automatic logic [CUR_W-1:0] avg4(logic [4*CUR_W-1:0] h);
        logic [CUR_W+1:0] s;
        s = {2'b00, h[CUR_W-1:0]} + {2'b00, h[2*CUR_W-1:CUR_W]}
          + {2'b00, h[3*CUR_W-1:2*CUR_W]} + {2'b00, h[4*CUR_W-1:3*CUR_W]};
        avg4 = s[CUR_W+1:2];
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [CUR_W-1:0]   i_low_q, i_high_q, i_over_q;
    logic [TMR_W-1:0]   t_set_q, t_max_q, t_min_q;
    logic               force_en_q, force_blk_q;
    logic [CNT_W-1:0]   act_cnt_q, blk_cnt_q, tick_ts_q;
    logic [2:0]         low_pu_q, high_pu_q, over_pu_q;
    logic [2:0]         low_pu_d, high_pu_d, over_pu_d;
    logic [2:0]         blk_sync_q;
    logic               blk_filt_q, blk_smp_q, blk_now;
    clpd_state_t        state_q;
    logic [TMR_W-1:0]   arm_cnt_q, max_cnt_q, min_cnt_q;
    logic               inrush_q;
    logic [4*CUR_W-1:0] hist_q [3];
    logic [CUR_W-1:0]   pre_q [3];
    logic [CUR_W-1:0]   evt_q [3];
    logic [2:0]         evt_type_q;
    logic [CNT_W-1:0]   evt_ts_q;
    logic [CUR_W-1:0]   cur [3];
    logic               low_all, high_all, over_any;
    logic               wr_en, rd_en, cnt_clr;
    logic               go_active, go_blocked, release_act;
    logic               tick;

    assign cur[0]  = meas.phase_a_rms;
    assign cur[1]  = meas.phase_b_rms;
    assign cur[2]  = meas.phase_c_rms;
    assign tick    = clk_en & meas_valid;

    // ------------------------------------------------------------
    // apb slave: zero wait state, frozen when the enable is low
    // ------------------------------------------------------------
    assign pready  = clk_en;
    assign wr_en   = clk_en & psel & penable & pwrite;
    assign rd_en   = clk_en & psel & penable & ~pwrite;
    assign cnt_clr = wr_en & (paddr == OFS_CTRL) & pwdata[CTRL_CNT_CLR];

    // unmapped offsets answer with an error
    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_I_LOW, OFS_I_HIGH, OFS_I_OVER, OFS_T_SET, OFS_T_MAX,
            OFS_T_MIN, OFS_STATUS, OFS_ACT_CNT, OFS_BLK_CNT, OFS_PRE_AB,
            OFS_PRE_C, OFS_EVT_AB, OFS_EVT_C, OFS_EVT_TS: pslverr = 1'b0;
            default: pslverr = psel & penable;
        endcase
    end

    // settings written by software
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            i_low_q     <= I_LOW_DEF;
            i_high_q    <= I_HIGH_DEF;
            i_over_q    <= I_OVER_DEF;
            t_set_q     <= T_SET_DEF;
            t_max_q     <= T_MAX_DEF;
            t_min_q     <= T_MIN_DEF;
            force_en_q  <= 1'b0;
            force_blk_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTRL: begin
                    force_en_q  <= pwdata[CTRL_FORCE_EN];
                    force_blk_q <= pwdata[CTRL_FORCE_BLK];
                end
                OFS_I_LOW:  i_low_q  <= pwdata[CUR_W-1:0];
                OFS_I_HIGH: i_high_q <= pwdata[CUR_W-1:0];
                OFS_I_OVER: i_over_q <= pwdata[CUR_W-1:0];
                OFS_T_SET:  t_set_q  <= pwdata[TMR_W-1:0];
                OFS_T_MAX:  t_max_q  <= pwdata[TMR_W-1:0];
                OFS_T_MIN:  t_min_q  <= pwdata[TMR_W-1:0];
                default: ;
            endcase
        end
    end

    // read data registered so it stands for the access phase edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en & psel & ~penable & ~pwrite) begin
            case (paddr)
                OFS_CTRL:    prdata <= {30'h0, force_blk_q, force_en_q};
                OFS_I_LOW:   prdata <= {16'h0, i_low_q};
                OFS_I_HIGH:  prdata <= {16'h0, i_high_q};
                OFS_I_OVER:  prdata <= {16'h0, i_over_q};
                OFS_T_SET:   prdata <= {13'h0, t_set_q};
                OFS_T_MAX:   prdata <= {13'h0, t_max_q};
                OFS_T_MIN:   prdata <= {13'h0, t_min_q};
                OFS_STATUS:  prdata <= {24'h0, 1'b0, condition_code, blk_smp_q,
                                        inrush_q, blocked, cold_load_active};
                OFS_ACT_CNT: prdata <= act_cnt_q;
                OFS_BLK_CNT: prdata <= blk_cnt_q;
                OFS_PRE_AB:  prdata <= {pre_q[1], pre_q[0]};
                OFS_PRE_C:   prdata <= {16'h0, pre_q[2]};
                OFS_EVT_AB:  prdata <= {evt_q[1], evt_q[0]};
                OFS_EVT_C:   prdata <= {13'h0, evt_type_q, evt_q[2]};
                OFS_EVT_TS:  prdata <= evt_ts_q;
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // block input: three stages, change taken once the last two stages agree
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            blk_sync_q <= 3'b000;
            blk_filt_q <= 1'b0;
        end else if (clk_en) begin
            blk_sync_q <= {blk_sync_q[1:0], block_in};
            if (blk_sync_q[1] == blk_sync_q[2])
                blk_filt_q <= blk_sync_q[2];
        end
    end

    // forcing mode hands the block input to software
    assign blk_now = force_en_q ? force_blk_q : blk_filt_q;

    // sampled at the tick for the status register; pick-up and timers use blk_now in that same cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            blk_smp_q <= 1'b0;
        else if (tick)
            blk_smp_q <= blk_now;
    end

    // ------------------------------------------------------------
    // comparators, one shared setting per threshold
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            low_pu_d[p]  = cmp_under(low_pu_q[p], cur[p], i_low_q);
            high_pu_d[p] = cmp_over(high_pu_q[p], cur[p], i_high_q);
            over_pu_d[p] = cmp_over(over_pu_q[p], cur[p], i_over_q);
        end
    end

    assign low_all  = &low_pu_d;
    assign high_all = &high_pu_d;
    assign over_any = |over_pu_d;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_pu_q  <= 3'b000;
            high_pu_q <= 3'b000;
            over_pu_q <= 3'b000;
        end else if (tick) begin
            low_pu_q  <= low_pu_d;
            high_pu_q <= high_pu_d;
            over_pu_q <= over_pu_d;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // pick-up once low has lasted the arming time; zero arms at once
    assign go_active  = tick & low_all & ~blk_now & ~state_q[1]
                      & reached(arm_cnt_q + 1'b1, t_set_q);
    assign go_blocked = tick & low_all & blk_now & ~state_q[1]
                      & reached(arm_cnt_q + 1'b1, t_set_q);

    // release: overcurrent, block, max expiry, or hold over with no inrush
    always_comb begin
        release_act = 1'b0;
        if (over_any | blk_now)
            release_act = 1'b1;
        else if (high_all)
            release_act = reached(max_cnt_q + 1'b1, t_max_q);
        else
            release_act = reached(min_cnt_q + 1'b1, t_min_q);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= ST_IDLE;
            arm_cnt_q <= '0;
            max_cnt_q <= '0;
            min_cnt_q <= '0;
            inrush_q  <= 1'b0;
        end else if (tick) begin
            case (state_q)
                ST_IDLE, ST_ARMING: begin
                    max_cnt_q <= '0;
                    min_cnt_q <= '0;
                    inrush_q  <= 1'b0;
                    if (!low_all) begin
                        state_q   <= ST_IDLE;
                        arm_cnt_q <= '0;
                    end else if (go_active) begin
                        state_q   <= ST_ACTIVE;
                        arm_cnt_q <= '0;
                    end else if (go_blocked) begin
                        state_q   <= ST_BLOCKED;
                        arm_cnt_q <= '0;
                    end else begin
                        state_q   <= ST_ARMING;
                        arm_cnt_q <= arm_cnt_q + 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    // hold timer runs from activation, max timer only in inrush
                    min_cnt_q <= min_cnt_q + 1'b1;
                    if (high_all) begin
                        inrush_q  <= 1'b1;
                        max_cnt_q <= max_cnt_q + 1'b1;
                    end else begin
                        inrush_q  <= 1'b0;
                    end
                    if (release_act)
                        state_q <= ST_IDLE;
                end
                ST_BLOCKED: begin
                    // nothing more is done until pick-up falls away
                    if (!low_all)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // inrush keeps the hold from ending the activation early
    // (while high the max timer rules; below high the hold timer does)

    // ------------------------------------------------------------
    // outputs and condition code, all from flip-flops
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cold_load_active <= 1'b0;
            blocked          <= 1'b0;
            condition_code   <= COND_NORMAL;
        end else if (tick) begin
            cold_load_active <= (state_q == ST_ACTIVE) ? ~release_act : go_active;
            blocked          <= (state_q == ST_BLOCKED) ? low_all : go_blocked;
            if ((state_q == ST_BLOCKED) ? low_all : go_blocked)
                condition_code <= COND_BLOCKED;
            else if ((state_q == ST_ACTIVE) ? ~release_act : go_active)
                condition_code <= COND_ACTIVE;
            else if (over_any)
                condition_code <= COND_OVER;
            else if (low_all)
                condition_code <= COND_LOW;
            else
                condition_code <= COND_NORMAL;
        end
    end

    // ------------------------------------------------------------
    // blocking event: one pulse with stamp, currents and fault type
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            block_event <= 1'b0;
            evt_ts_q    <= '0;
            evt_type_q  <= 3'b000;
            for (int p = 0; p < 3; p++)
                evt_q[p] <= '0;
        end else if (clk_en) begin
            block_event <= go_blocked & (state_q != ST_BLOCKED);
            if (go_blocked & (state_q != ST_BLOCKED)) begin
                evt_ts_q   <= tick_ts_q;
                evt_type_q <= over_pu_d;                     // phases above overcurrent
                for (int p = 0; p < 3; p++)
                    evt_q[p] <= cur[p];
            end
        end
    end

    // ------------------------------------------------------------
    // tick time stamp and activation counters
    // ------------------------------------------------------------
    // an event in the clearing cycle is counted, not lost
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_ts_q <= '0;
            act_cnt_q <= '0;
            blk_cnt_q <= '0;
        end else if (clk_en) begin
            if (tick)
                tick_ts_q <= tick_ts_q + 1'b1;
            if (go_active & (state_q != ST_ACTIVE))
                act_cnt_q <= cnt_clr ? CNT_W'(1) : act_cnt_q + 1'b1;
            else if (cnt_clr)
                act_cnt_q <= '0;
            if (go_blocked & (state_q != ST_BLOCKED))
                blk_cnt_q <= cnt_clr ? CNT_W'(1) : blk_cnt_q + 1'b1;
            else if (cnt_clr)
                blk_cnt_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // 20 ms history; its average is latched as pre-fault on activation
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < 3; p++) begin
                hist_q[p] <= '0;
                pre_q[p]  <= '0;
            end
        end else if (tick) begin
            for (int p = 0; p < 3; p++) begin
                hist_q[p] <= {hist_q[p][3*CUR_W-1:0], cur[p]};
                if (go_active & (state_q != ST_ACTIVE))
                    pre_q[p] <= avg4(hist_q[p]);
            end
        end
    end

endmodule // clpd_detector

`default_nettype wire

// *** dv/clpd_chk.sv ***
// assertion checker for the cold load pick-up detector ports
`timescale 1ns/1ps
`default_nettype none
module clpd_chk (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  arst_n,
    // watched ports
    input wire logic                  clk_en,
    input wire clpd_pkg::clpd_phase_t meas,
    input wire logic                  meas_valid,
    input wire logic                  cold_load_active,
    input wire logic                  blocked,
    input wire logic [2:0]            condition_code,
    input wire logic                  block_event
);
    import clpd_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // thresholds stay at their defaults in the bench, so the checker may use them
    wire logic tk = meas_valid && clk_en;
    wire logic ov = meas.phase_a_rms > I_OVER_DEF || meas.phase_c_rms > I_OVER_DEF;
    wire logic lo = meas.phase_a_rms <= I_LOW_DEF && meas.phase_b_rms <= I_LOW_DEF
                    && meas.phase_c_rms <= I_LOW_DEF;
    a_out_excl: assert property (!(cold_load_active && blocked))
        else $error("active and blocked together");
    a_evt_once: assert property (block_event |=> !block_event)
        else $error("block event longer than one cycle");
    a_evt_entry: assert property (block_event |-> $rose(blocked))
        else $error("block event without blocked entry");
    a_cond_act: assert property (cold_load_active |-> condition_code == 3'h3)
        else $error("condition code not active");
    a_cond_blk: assert property (blocked |-> condition_code == 3'h4)
        else $error("condition code not blocked");
    a_tick_only: assert property (!$past(tk) |-> $stable(cold_load_active)
        && $stable(blocked)) else $error("output moved without a tick");
    a_over_drop: assert property (tk && ov && cold_load_active |=> !cold_load_active)
        else $error("overcurrent did not drop active");
    a_low_need: assert property ($rose(cold_load_active) |-> $past(tk && lo))
        else $error("active rose without low current tick");
endmodule // clpd_chk
bind clpd_detector clpd_chk u_chk (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .meas(meas), .meas_valid(meas_valid), .cold_load_active(cold_load_active),
    .blocked(blocked), .condition_code(condition_code), .block_event(block_event));
`default_nettype wire

// *** dv/clpd_meas_src.sv ***
// measurement front end model: one sample per bench request
`timescale 1ns/1ps
`default_nettype none
module clpd_meas_src (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // request and sample from the bench
    input  wire logic                  req,
    input  wire clpd_pkg::clpd_phase_t cur,
    // to the detector
    output var  clpd_pkg::clpd_phase_t meas,
    output var  logic                  meas_valid
);
    import clpd_pkg::*;
    // one valid pulse per request keeps bench and detector on the same tick count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) meas_valid <= 1'b0;
        else meas_valid <= req;
    end
    // off the valid cycle the bus shows the inverse, so a stray sample is caught
    assign meas = meas_valid ? cur : ~cur;
endmodule // clpd_meas_src
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the cold load pick-up detector
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import clpd_pkg::*;
    logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, req = 0, block_in = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, cold_load_active, blocked, block_event, meas_valid, en = 1;
    logic [2:0] condition_code;
    clpd_phase_t cur = '0, meas;
    int n_fail = 0, checks_done = 0, seed = 32'hbda9;
    int ma = 0, mb = 0, lc = 0, xc = 0, nc = 0, na = 0, nb = 0, ts = 3, tx = 4, tn = 2;
    localparam int B[4] = '{0, 30, 130, 130};
    localparam logic [7:0] RA[6] = '{OFS_I_LOW, OFS_I_HIGH, OFS_I_OVER, OFS_T_SET, OFS_T_MAX,
                                     OFS_T_MIN};
    localparam int RE[6] = '{20, 120, 200, 2000, 6000, 8};
    localparam int SQ[38] = '{1, 0, 0, 0, 1, 1, 1, 0, 0, 0, 2, 2, 1, 1, 0, 0, 0, 2, 2, 2, 2,
                              1, 0, 0, 0, 2, 3, 1, 0, 0, 0, 5, 1, 4, 4, 4, 5, 1};
    localparam int SF[5] = '{8, 8, 8, 9, 1}, SZ[4] = '{0, 19, 3, 1};
    initial forever #10 core_clk = ~core_clk;
    clpd_detector uut (.core_clk, .arst_n, .clk_en(en), .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .meas, .meas_valid, .block_in,
        .cold_load_active, .blocked, .condition_code, .block_event);
    clpd_meas_src u_src (.core_clk, .arst_n, .req, .cur, .meas, .meas_valid);
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // band 1 mixes one low phase into mid ones; band 3 puts only phase c over
    function automatic clpd_phase_t mk(input int g);
        clpd_phase_t p;
        p = {16'(B[g] + (rnd() & 15)), 16'(B[g] + (rnd() & 15)), 16'(B[g] + (rnd() & 15))};
        if (g == 1) p.phase_a_rms = 16'(rnd() & 15);
        if (g == 3) p.phase_c_rms = 16'(210 + (rnd() & 15));
        return p;
    endfunction
    task chk(input logic [32:0] s, input logic [32:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // s: band in bits 1:0, block pin in bit 2, forced block in bit 3, freeze in bit 4
    task tick(input int s);
        int b, lo, hi, ov, ev;
        b = (s >> 2) != 0;
        lo = (s & 3) == 0;
        hi = (s & 3) >= 2;
        ov = (s & 3) == 3;
        ev = 0;
        @(posedge core_clk);
        cur <= mk(s & 3);
        block_in <= s[2];
        en <= !s[4];
        repeat (6) @(posedge core_clk); // pin filter settles well before the tick
        req <= 1'b1;
        @(posedge core_clk);
        req <= 1'b0;
        @(posedge core_clk);
        #1;
        if (ma && !s[4]) begin
            nc++;
            xc = hi ? xc + 1 : 0;
            if (ov || b) ma = 0;
            else if (hi) ma = xc < tx;
            else if (nc >= tn) ma = 0;
        end else if (mb) mb = lo;
        else if (lo && ++lc >= ts) begin
            {ma, mb, ev, nc, xc, lc} = {!b, b, b, 0, 0, 0};
            na += !b;
            nb += b;
        end else if (!lo) lc = 0;
        chk(cold_load_active, ma);
        chk(blocked, mb);
        chk(block_event, ev);
        chk(condition_code, mb ? 4 : ma ? 3 : ov ? 2 : lo ? 1 : 0);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // the run needs about 500 cycles; far beyond that it counts as hung
    initial begin
        #200us;
        n_fail++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        #1 chk({cold_load_active, blocked, condition_code, block_event}, 0);
        for (int i = 0; i < 6; i++) begin
            apb(0, RA[i], 0);
            chk(rd, RE[i]);
        end
        apb(0, 8'h3c, 0);
        chk({er, rd}, 33'h100000000);
        apb(1, OFS_T_SET, 3);
        apb(1, OFS_T_MAX, 4);
        apb(1, OFS_T_MIN, 2);
        $display("test registers done");
        foreach (SQ[i]) tick(SQ[i]);
        apb(1, OFS_CTRL, 3);
        foreach (SF[i]) tick(SF[i]);
        apb(1, OFS_CTRL, 0);
        apb(1, OFS_T_SET, 0);
        ts = 0;
        foreach (SZ[i]) tick(SZ[i]);
        $display("test sequences done");
        apb(0, OFS_ACT_CNT, 0);
        chk(rd, na);
        apb(0, OFS_BLK_CNT, 0);
        chk(rd, nb);
        apb(1, OFS_CTRL, 4);
        apb(0, OFS_ACT_CNT, 0);
        chk(rd, 0);
        $display("test counters done");
        summarize;
    end
endmodule // testbench
`default_nettype wire
